// file: core/uglyph_lookup.sv
`timescale 1ns/1ps
// user glyph lookup: character code plus row to lit dot columns, two cycle latency
module uglyph_lookup (
	input  wire logic                            clk,
	input  wire logic                            rst_n,
	input  wire logic                            font_5x10,
	input  wire logic [uglyph_pkg::CODE_W-1:0]   char_code,
	input  wire logic [3:0]                      row_idx,
	input  wire logic                            cursor_on,
	input  wire logic                            wr_en,
	input  wire logic [uglyph_pkg::ADDR_W-1:0]   wr_addr,
	input  wire logic [uglyph_pkg::DATA_W-1:0]   wr_data,
	output logic                                 user_hit,
	output logic      [uglyph_pkg::DOTS-1:0]     dots
);
	////////////////////////////////////////////////////////////////////////////////
	// decode helpers, shared by the datapath and by the checks below
	//
	// timing of one lookup, counted from the edge that samples the inputs:
	//   edge 0: char_code, row_idx, font_5x10 and cursor_on are sampled,
	//           the memory read address is launched and the side bits stored
	//   edge 1: the row byte stands in row_data, the dot columns are formed
	//   edge 2: dots and user_hit stand for one cycle
	// the side bits travel in a one-deep register chain so they meet the row
	// byte of their own lookup; a slower memory would need a deeper chain
	// codes with a nonzero upper nibble still read the memory, but their byte
	// is masked: reading always keeps the memory port free of extra muxing

	// a code picks user memory only when its upper nibble is zero
	function automatic logic user_code(
		input logic [uglyph_pkg::CODE_W-1:0] code
	);
		return (code[7:4] == uglyph_pkg::USER_HIGH);
	endfunction

	// memory address for one glyph row; code bit 3 never takes part
	function automatic logic [uglyph_pkg::ADDR_W-1:0] glyph_addr(
		input logic                          wide,
		input logic [uglyph_pkg::CODE_W-1:0] code,
		input logic [3:0]                    row
	);
		if (wide) begin
			return {code[2:1], row};
		end
		return {code[2:0], row[2:0]};
	endfunction

	// 5x10 rows past the cursor row are never shown; 5x8 uses every row
	function automatic logic row_shown(
		input logic       wide,
		input logic [3:0] row
	);
		if (wide) begin
			return (row <= uglyph_pkg::ROW10_CURSOR);
		end
		return 1'b1;
	endfunction

	// the last shown row of a glyph carries the cursor
	function automatic logic cursor_row(
		input logic       wide,
		input logic [3:0] row
	);
		if (wide) begin
			return (row == uglyph_pkg::ROW10_CURSOR);
		end
		return (row[2:0] == uglyph_pkg::ROW8_CURSOR[2:0]);
	endfunction

	// column view of a row byte for the checks: dots[0] takes data bit 4
	function automatic logic [uglyph_pkg::DOTS-1:0] flip_dots(
		input logic [uglyph_pkg::DATA_W-1:0] data
	);
		return {data[0], data[1], data[2], data[3], data[4]};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// address forming
	logic [uglyph_pkg::ADDR_W-1:0] rd_addr;
	logic                          hit_now;
	logic                          row_ok;
	logic                          cur_now;

	// only the upper nibble picks user memory; bit 3 never takes part
	assign hit_now = user_code(char_code);
	// 5x8: code[2:0] glyph, row[2:0] line; 5x10: code[2:1] glyph, row[3:0] line
	assign rd_addr = glyph_addr(font_5x10, char_code, row_idx);
	// rows past the cursor row of a 5x10 glyph are blank
	assign row_ok  = row_shown(font_5x10, row_idx);
	assign cur_now = cursor_row(font_5x10, row_idx);

	////////////////////////////////////////////////////////////////////////////////
	// storage and pipeline alignment with the registered memory read
	logic [uglyph_pkg::DATA_W-1:0] row_data;
	logic                          hit_ff;
	logic                          ok_ff;
	logic                          cur_ff;
	logic                          con_ff;
	logic [uglyph_pkg::DOTS-1:0]   nxt_dots;
	logic [uglyph_pkg::DOTS-1:0]   dots_ff;
	logic                          hitq_ff;

	uglyph_mem u_mem (
		.clk     (clk),
		.wr_en   (wr_en),
		.wr_addr (wr_addr),
		.wr_data (wr_data),
		.rd_addr (rd_addr),
		.rd_data (row_data)
	);

	// side info follows the read by one cycle so it lines up with row_data
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hit_ff <= 1'b0;
			ok_ff  <= 1'b0;
			cur_ff <= 1'b0;
			con_ff <= 1'b0;
		end else begin
			hit_ff <= hit_now;
			ok_ff  <= row_ok;
			cur_ff <= cur_now;
			con_ff <= cursor_on;
		end
	end

	uglyph_dots u_dots (
		.row_data   (row_data),
		.row_valid  (hit_ff & ok_ff),
		.cursor_row (cur_ff),
		.cursor_on  (con_ff),
		.dots       (nxt_dots)
	);

	// outputs registered so the dot data never glitches (two cycles total)
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dots_ff <= '0;
			hitq_ff <= 1'b0;
		end else begin
			dots_ff <= nxt_dots;
			hitq_ff <= hit_ff;
		end
	end
	assign dots     = dots_ff;
	assign user_hit = hitq_ff;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	a_ignored_code: assert property (@(posedge clk) disable iff (!rst_n)
		!$past(hit_now) |-> ##1 (dots == '0)) else $error("non user code lit dots");
	a_rows_blank: assert property (@(posedge clk) disable iff (!rst_n)
		(font_5x10 && row_idx > uglyph_pkg::ROW10_CURSOR) |-> ##2 (dots == '0))
		else $error("5x10 row past cursor row lit");
	a_cursor_or: assert property (@(posedge clk) disable iff (!rst_n)
		(hit_now && cursor_on && !font_5x10 && row_idx[2:0] == 3'h7) |-> ##2 (dots == 5'h1f))
		else $error("cursor row not fully lit");
	a_cursor10_or: assert property (@(posedge clk) disable iff (!rst_n)
		(hit_now && cursor_on && font_5x10 && row_idx == 4'ha) |-> ##2 (dots == 5'h1f))
		else $error("5x10 cursor row not fully lit");
	a_cursor_off: assert property (@(posedge clk) disable iff (!rst_n)
		(hit_now && !cursor_on) |-> ##2
		((dots & ~flip_dots($past(row_data))) == 5'h0)) else $error("cursor lit while off");
	a_col_order: assert property (@(posedge clk) disable iff (!rst_n)
		(hit_ff && ok_ff && !(cur_ff && con_ff)) |-> ##1
		(dots == {$past(row_data[0]), $past(row_data[1]), $past(row_data[2]),
		$past(row_data[3]), $past(row_data[4])})) else $error("column order wrong");
	a_addr8: assert property (@(posedge clk) disable iff (!rst_n)
		!font_5x10 |-> (rd_addr[5:3] == char_code[2:0] && rd_addr[2:0] == row_idx[2:0]))
		else $error("5x8 address wrong");
	a_addr10: assert property (@(posedge clk) disable iff (!rst_n)
		font_5x10 |-> (rd_addr[5:4] == char_code[2:1] && rd_addr[3:0] == row_idx))
		else $error("5x10 address wrong");
	a_hit_delay: assert property (@(posedge clk) disable iff (!rst_n)
		##2 (user_hit == $past(char_code[7:4] == 4'h0, 2))) else $error("hit latency");

	////////////////////////////////////////////////////////////////////////////////
	// stage checks: every register of the chain carries its own lookup
	// the chain checks are guarded by the previous reset level, because the
	// first edge after release still shows the cleared stage, not the input
	// limitation: the memory is not reset, so a lookup of a row that the host
	// never wrote shows unknown dots; the checks that compare against the row
	// byte are only meaningful once the host has filled the rows in use
	// the cursor checks look at the whole row: the cursor is a full line here,
	// not an underline of some columns, which keeps the OR a single gate level

	// the user memory is chosen by the upper nibble alone
	a_hit_decode: assert property (@(posedge clk) disable iff (!rst_n)
		hit_now == (char_code[7:4] == 4'h0))
		else $error("user code decode wrong");

	// the hit flag follows the sampled code by one edge
	a_hit_stage: assert property (@(posedge clk) disable iff (!rst_n)
		$past(rst_n) |-> (hit_ff == $past(hit_now)))
		else $error("hit stage out of step");

	// the hit output follows the hit stage by one edge
	a_hit_out: assert property (@(posedge clk) disable iff (!rst_n)
		$past(rst_n) |-> (user_hit == $past(hit_ff)))
		else $error("hit output out of step");

	// the row shown flag travels with its row byte
	a_row_stage: assert property (@(posedge clk) disable iff (!rst_n)
		$past(rst_n) |-> (ok_ff == $past(row_ok)))
		else $error("row stage out of step");

	// the cursor row flag travels with its row byte
	a_cur_stage: assert property (@(posedge clk) disable iff (!rst_n)
		$past(rst_n) |-> (cur_ff == $past(cur_now)))
		else $error("cursor row stage out of step");

	// the cursor enable travels with its row byte
	a_con_stage: assert property (@(posedge clk) disable iff (!rst_n)
		$past(rst_n) |-> (con_ff == $past(cursor_on)))
		else $error("cursor enable stage out of step");

	// the dot output is the registered column word
	a_dots_stage: assert property (@(posedge clk) disable iff (!rst_n)
		$past(rst_n) |-> (dots == $past(nxt_dots)))
		else $error("dot output out of step");

	// every 5x8 row is a shown row
	a_narrow_rows: assert property (@(posedge clk) disable iff (!rst_n)
		!font_5x10 |-> row_ok)
		else $error("5x8 row hidden");

	// 5x10 rows up to the cursor row are shown, later ones are not
	a_wide_rows: assert property (@(posedge clk) disable iff (!rst_n)
		font_5x10 |-> (row_ok == (row_idx <= 4'ha)))
		else $error("5x10 row range wrong");

	// the eighth row is the only 5x8 cursor row
	a_narrow_cur_sel: assert property (@(posedge clk) disable iff (!rst_n)
		!font_5x10 |-> (cur_now == (row_idx[2:0] == 3'h7)))
		else $error("5x8 cursor row wrong");

	// the eleventh row is the only 5x10 cursor row
	a_wide_cur_sel: assert property (@(posedge clk) disable iff (!rst_n)
		font_5x10 |-> (cur_now == (row_idx == 4'ha)))
		else $error("5x10 cursor row wrong");

	// the cursor lights nothing outside its own row
	a_cursor_no_leak: assert property (@(posedge clk) disable iff (!rst_n)
		(hit_now && cursor_on && !cur_now) |-> ##2
		((dots & ~flip_dots($past(row_data))) == 5'h0)) else $error("cursor leaked");

	// with the cursor off a stray bit in the 5x8 cursor row still lights
	a_stray_bit8: assert property (@(posedge clk) disable iff (!rst_n)
		(hit_now && !cursor_on && !font_5x10 && row_idx[2:0] == 3'h7) |-> ##2
		(dots == flip_dots($past(row_data)))) else $error("5x8 stray bit lost");

	// with the cursor off a stray bit in the 5x10 cursor row still lights
	a_stray_bit10: assert property (@(posedge clk) disable iff (!rst_n)
		(hit_now && !cursor_on && font_5x10 && row_idx == 4'ha) |-> ##2
		(dots == flip_dots($past(row_data)))) else $error("5x10 stray bit lost");

	// reset leaves the outputs dark and the hit flag low
	a_reset_dark: assert property (@(posedge clk)
		!rst_n |-> ##1 (dots == 5'h0 && !user_hit))
		else $error("outputs not cleared by reset");

	// set bits above the five columns never light a dot
	a_high_bits_dark: assert property (@(posedge clk) disable iff (!rst_n)
		(hit_ff && ok_ff && row_data[4:0] == 5'h0 && !(cur_ff && con_ff)) |-> ##1
		(dots == 5'h0)) else $error("upper data bits lit");

	// a non user lookup in the middle stage gives a dark output
	a_dark_late: assert property (@(posedge clk) disable iff (!rst_n)
		!hit_ff |-> ##1 (dots == 5'h0))
		else $error("masked lookup lit dots");

	// a non user code never raises the hit flag
	a_nonuser_stage: assert property (@(posedge clk) disable iff (!rst_n)
		!hit_now |-> ##1 !hit_ff)
		else $error("hit stage set for non user code");

	// a user code raises the hit output two edges later
	a_user_out: assert property (@(posedge clk) disable iff (!rst_n)
		hit_now |-> ##2 user_hit)
		else $error("user code missed");

	// a non user code keeps the hit output low two edges later
	a_nonuser_out: assert property (@(posedge clk) disable iff (!rst_n)
		!hit_now |-> ##2 !user_hit)
		else $error("non user code flagged");

	// a shown cursor row with the cursor on lights every column
	a_cursor_full_late: assert property (@(posedge clk) disable iff (!rst_n)
		(hit_ff && ok_ff && cur_ff && con_ff) |-> ##1 (dots == 5'h1f))
		else $error("cursor row stage not full");

	// a hidden row stays dark whatever its byte holds
	a_hidden_row_dark: assert property (@(posedge clk) disable iff (!rst_n)
		(hit_ff && !ok_ff) |-> ##1 (dots == 5'h0))
		else $error("hidden row lit");
endmodule // uglyph_lookup

// file: shared/uglyph_pkg.sv
// Functional notes
// - 5x8: code bits 2:0 become glyph memory address bits 5:3, eight glyphs
// - a one bit in glyph memory lights its dot, a zero leaves it dark
// - 5x8: address bits 2:0 select the row within the glyph
// - 5x8: eighth row is the cursor row, shown as pattern OR cursor
// - host keeps eighth row zero; any set bit there lights regardless of cursor
// - glyph memory is used whenever code bits 7:4 are all zero
// - 5x8: code bit 3 ignored, so 00h and 08h show the same glyph
// - row bits 4:0 drive five columns, bit 4 is the leftmost
// - 5x10: code bits 2:1 become address bits 5:4, four glyphs
// - 5x10: address bits 3:0 select the row within the glyph
// - 5x10: eleventh row is the cursor row, shown as pattern OR cursor
// - host keeps eleventh row zero; any set bit there lights regardless of cursor
// - 5x10: code bits 0 and 3 ignored, 00h 01h 08h 09h alike
package uglyph_pkg;
	localparam int CODE_W      = 8;
	localparam int ADDR_W      = 6;
	localparam int DATA_W      = 8;
	localparam int DOTS        = 5;
	localparam int DEPTH       = 64;
	localparam int ROW8_W      = 3;
	localparam int ROW10_W     = 4;
	localparam logic [3:0] ROW8_CURSOR  = 4'h7;
	localparam logic [3:0] ROW10_CURSOR = 4'ha;
	localparam logic [3:0] USER_HIGH    = 4'h0;
	localparam logic [DATA_W-1:0] MEM_RESET = 8'h00;
endpackage

// file: core/uglyph_mem.sv
`timescale 1ns/1ps
// small pattern store with registered read data
// a read of the address being written in the same cycle returns the old byte
module uglyph_mem #(
	parameter int AW = uglyph_pkg::ADDR_W,
	parameter int DW = uglyph_pkg::DATA_W
) (
	input  wire logic          clk,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [DW-1:0] wr_data,
	input  wire logic [AW-1:0] rd_addr,
	output logic      [DW-1:0] rd_data
);
	logic [DW-1:0] mem_ff [0:(1<<AW)-1];

	// no reset on the array: contents are undefined until the host writes them
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem_ff[wr_addr] <= wr_data;
		end
		rd_data <= mem_ff[rd_addr];
	end
endmodule // uglyph_mem

// file: core/uglyph_dots.sv
`timescale 1ns/1ps
// row byte to dot columns, column 0 is the leftmost on the panel
module uglyph_dots (
	input  wire logic [uglyph_pkg::DATA_W-1:0] row_data,
	input  wire logic                          row_valid,
	input  wire logic                          cursor_row,
	input  wire logic                          cursor_on,
	output logic      [uglyph_pkg::DOTS-1:0]   dots
);
	logic [uglyph_pkg::DOTS-1:0] pat;
	genvar gi;
	// bits 7:5 are dropped here on purpose
	generate
		for (gi = 0; gi < uglyph_pkg::DOTS; gi++) begin : g_col
			assign pat[gi] = row_data[uglyph_pkg::DOTS-1-gi];
		end
	endgenerate
	// one lights, zero stays dark; cursor ORs in without masking data
	// stray bits in a cursor row stay visible with the cursor off
	assign dots = row_valid ? (pat | {uglyph_pkg::DOTS{cursor_row & cursor_on}}) : '0;
endmodule // uglyph_dots

// file: tb/uglyph_host.sv
`timescale 1ns/1ps
// host side that fills the user glyph store, one strobe per byte
module uglyph_host (
	input  wire logic                          clk,
	output logic                               wr_en,
	output logic [uglyph_pkg::ADDR_W-1:0]      wr_addr,
	output logic [uglyph_pkg::DATA_W-1:0]      wr_data
);
	initial begin
		wr_en = 1'b0;
		wr_addr = 6'h00;
		wr_data = 8'h00;
	end
	// a well behaved host keeps cursor rows zero; the bench asks otherwise on purpose
	task automatic put(input logic [5:0] a, input logic [7:0] d);
		@(negedge clk);
		wr_en = 1'b1;
		wr_addr = a;
		wr_data = d;
		@(negedge clk);
		wr_en = 1'b0;
		wr_addr = ~a; // released lines must not look like the last value
		wr_data = ~d;
	endtask
endmodule // uglyph_host

// file: tb/user_glyph_pattern_lookup_tb.sv
`timescale 1ns/1ps
module user_glyph_pattern_lookup_tb;
	logic clk, rst_n, font_5x10, cursor_on, wr_en, user_hit;
	logic [7:0] char_code, wr_data;
	logic [3:0] row_idx;
	logic [5:0] wr_addr;
	logic [4:0] dots;
	int fails = 0, cmp_count = 0, cyc = 0;
	uglyph_host u_uglyph_host (.clk(clk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data));
	uglyph_lookup u_uglyph_lookup (.clk(clk), .rst_n(rst_n), .font_5x10(font_5x10),
		.char_code(char_code), .row_idx(row_idx), .cursor_on(cursor_on), .wr_en(wr_en),
		.wr_addr(wr_addr), .wr_data(wr_data), .user_hit(user_hit), .dots(dots));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// a hang is cut short well past the fifty or so cycles the run needs
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fails = fails + 1;
			stop_test();
		end
	end
	task automatic chk(input string what, input logic [4:0] seen, input logic [4:0] exp);
		cmp_count = cmp_count + 1;
		if (seen !== exp) begin
			fails = fails + 1;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// present one lookup, then judge it after the fixed two-edge latency
	task automatic look(input logic f, input logic [7:0] c, input logic [3:0] r,
		input logic cur, input logic [4:0] ed, input logic eh);
		@(negedge clk);
		font_5x10 = f;
		char_code = c;
		row_idx = r;
		cursor_on = cur;
		@(posedge clk);
		@(posedge clk);
		@(negedge clk);
		chk("dots", dots, ed);
		chk("user_hit", {4'h0, user_hit}, {4'h0, eh});
	endtask
	// 5x8 glyph 3 row 2, with code bit 3 set and unused data bits set
	task automatic t_narrow();
		u_uglyph_host.put(6'h1a, 8'hf3);
		look(1'b0, 8'h03, 4'h2, 1'b0, 5'h19, 1'b1);
		look(1'b0, 8'h0b, 4'h2, 1'b0, 5'h19, 1'b1);
		look(1'b0, 8'h13, 4'h2, 1'b0, 5'h00, 1'b0);
	endtask
	// 5x8 cursor row with a stray set bit
	task automatic t_narrow_cursor();
		u_uglyph_host.put(6'h2f, 8'h01);
		look(1'b0, 8'h0d, 4'h7, 1'b0, 5'h10, 1'b1);
		look(1'b0, 8'h05, 4'h7, 1'b1, 5'h1f, 1'b1);
	endtask
	// 5x10 glyph 2: code bits 0 and 3 ignored, cursor row and rows past it
	task automatic t_wide();
		u_uglyph_host.put(6'h2a, 8'h04);
		u_uglyph_host.put(6'h23, 8'h1e);
		u_uglyph_host.put(6'h2b, 8'h1f);
		look(1'b1, 8'h0d, 4'h3, 1'b0, 5'h0f, 1'b1);
		look(1'b1, 8'h04, 4'ha, 1'b0, 5'h04, 1'b1);
		look(1'b1, 8'h05, 4'ha, 1'b1, 5'h1f, 1'b1);
		look(1'b1, 8'h0c, 4'hb, 1'b1, 5'h00, 1'b1);
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		rst_n = 1'b0;
		font_5x10 = 1'b0;
		char_code = 8'h10; // idle on a non user code: unwritten rows would read as unknown
		row_idx = 4'h0;
		cursor_on = 1'b0;
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		t_narrow();
		t_narrow_cursor();
		t_wide();
		stop_test();
	end
endmodule // user_glyph_pattern_lookup_tb
